//--- verilog/rtcta_irq.sv
// Fixed-cycle timer and alarm interrupt logic with open-drain interrupt pins
`timescale 1ns/1ps
`include "rtcta_params.svh"
module rtcta_irq
   import rtcta_pkg::*;
#(
   parameter logic [`RTCTA_RTN_W-1:0] RTN_CYCLES = `RTCTA_RTN_W'(`RTCTA_RTN_CYCLES)
) (
   input  wire logic                     clock,      // 125 MHz system clock
   input  wire logic                     reset_n,    // Async reset, active low
   input  wire logic [`RTCTA_ADDR_W-1:0] addr,       // Register address
   input  wire logic [7:0]               wrData,     // Write data
   input  wire logic                     wrEn,       // Write strobe
   input  wire logic                     rdEn,       // Read strobe
   output logic      [7:0]               rdData,     // Read data, cycle after rdEn
   input  wire logic                     tick4096,   // 4096 Hz time base pulse
   input  wire logic                     tick64,     // 64 Hz time base pulse
   input  wire logic                     secTick,    // Seconds update pulse
   input  wire logic                     minTick,    // Minutes update pulse
   input  wire logic [6:0]               curMinute,  // Current minute, BCD
   input  wire logic [5:0]               curHour,    // Current hour, BCD
   input  wire logic [5:0]               curDay,     // Current date, BCD
   input  wire logic [2:0]               curWeekday, // Current weekday
   output logic                          tirqOut,    // Timer pin level when driven
   output logic                          tirqOe,     // Timer pin pulled low
   output logic                          airqOut,    // Alarm pin level when driven
   output logic                          airqOe,     // Alarm pin pulled low
   output logic                          intOut,     // Shared pin level when driven
   output logic                          intOe       // Shared pin pulled low
);

   rtcta_state_t st;
   rtcta_state_t n;
   logic         srcTick;
   logic         tmrEvt;
   logic         matchNow;
   logic         almEvt;
   logic [3:0]   ignore;

   function automatic logic pickTick(input logic [1:0] sel, input logic t0, input logic t1,
                                     input logic t2, input logic t3);
      case (sel)
         `RTCTA_SRC_4096: pickTick = t0;
         `RTCTA_SRC_64:   pickTick = t1;
         `RTCTA_SRC_SEC:  pickTick = t2;
         default:         pickTick = t3;
      endcase
   endfunction

   // Field matches when ignored or equal in the valid bits
   function automatic logic fieldHit(input logic [7:0] alm, input logic [6:0] cur, input logic [6:0] mask);
      fieldHit = alm[`RTCTA_B_IGNORE] || ((alm[6:0] & mask) == (cur & mask));
   endfunction

   always_comb begin
      n = st;
      n.rdData = 8'h00;
      if (wrEn) begin
         case (addr)
            `RTCTA_A_CTRL2: begin
               n.pulseMode = wrData[`RTCTA_B_PULSE];
               n.alarm_irq_enable       = wrData[`RTCTA_B_AIE];
               n.timer_irq_enable       = wrData[`RTCTA_B_TIE];
               if (!wrData[`RTCTA_B_TF]) begin
                  n.tf = 1'b0;
               end
               if (!wrData[`RTCTA_B_AF]) begin
                  n.af = 1'b0;
               end
            end
            `RTCTA_A_TMR_CTRL: begin
               n.td = wrData[1:0];
               n.te = wrData[`RTCTA_B_TE];
            end
            `RTCTA_A_PRESET: begin
               if (!st.te) begin
                  n.preset = wrData;
                  n.count  = wrData;
               end
            end
            `RTCTA_A_ALM_MIN:  n.almMin  = wrData;
            `RTCTA_A_ALM_HOUR: n.almHour = wrData;
            `RTCTA_A_ALM_DAY:  n.almDay  = wrData;
            `RTCTA_A_ALM_WDAY: n.almWday = wrData;
            default: ;
         endcase
      end

      // Source tick; start is not aligned to it, so the first period can be short
      srcTick = pickTick(st.td, tick4096, tick64, secTick, minTick);
      tmrEvt  = (st.state == TMR_RUN) && n.te && srcTick && (st.count == `RTCTA_CNT_ONE);

      case (st.state)
         TMR_IDLE: begin
            if (n.te && !st.te) begin
               n.state = TMR_RUN;
               n.count = st.preset;
            end
         end
         TMR_RUN: begin
            if (!n.te) begin
               n.state = TMR_IDLE;
            end else if (srcTick) begin
               if (st.count == `RTCTA_CNT_ONE) begin
                  n.count = st.preset;
               end else if (st.count != `RTCTA_CNT_ZERO) begin
                  n.count = st.count - 8'h01;
               end
            end
         end
         default: n.state = TMR_IDLE;
      endcase

      // Event set wins over a software clear in the same cycle
      if (tmrEvt) begin
         n.tf = 1'b1;
      end

      if (st.rtn != '0) begin
         n.rtn = st.rtn - `RTCTA_RTN_W'(1);
      end
      if (tmrEvt && st.pulseMode && n.timer_irq_enable) begin
         n.rtn = RTN_CYCLES;
      end

      ignore   = {st.almMin[`RTCTA_B_IGNORE], st.almHour[`RTCTA_B_IGNORE],
                  st.almDay[`RTCTA_B_IGNORE], st.almWday[`RTCTA_B_IGNORE]};
      matchNow = fieldHit(st.almMin, curMinute, 7'h7f)
              && fieldHit(st.almHour, {1'b0, curHour}, 7'h3f)
              && fieldHit(st.almDay, {1'b0, curDay}, 7'h3f)
              && fieldHit(st.almWday, {4'h0, curWeekday}, 7'h07)
              && (ignore != `RTCTA_IGN_ALL);
      almEvt      = matchNow && !st.matchPrev;
      n.matchPrev = matchNow;
      if (almEvt) begin
         n.af = 1'b1;
      end

      // Pin requests
      if (n.pulseMode) begin
         n.tOe = (n.rtn != '0);
      end else begin
         n.tOe = n.tf && n.timer_irq_enable;
      end
      n.aOe = n.af && n.alarm_irq_enable;
      n.iOe = n.tOe || n.aOe;
      n.pinLevel = 1'b0;

      if (rdEn) begin
         case (addr)
            `RTCTA_A_CTRL2: begin
               n.rdData[`RTCTA_B_PULSE] = st.pulseMode;
               n.rdData[`RTCTA_B_AF]    = st.af;
               n.rdData[`RTCTA_B_TF]    = st.tf;
               n.rdData[`RTCTA_B_AIE]   = st.alarm_irq_enable;
               n.rdData[`RTCTA_B_TIE]   = st.timer_irq_enable;
            end
            `RTCTA_A_TMR_CTRL: begin
               n.rdData[1:0]          = st.td;
               n.rdData[`RTCTA_B_TE]  = st.te;
            end
            `RTCTA_A_PRESET:   n.rdData = (st.state == TMR_RUN) ? st.count : st.preset;
            `RTCTA_A_ALM_MIN:  n.rdData = st.almMin;
            `RTCTA_A_ALM_HOUR: n.rdData = st.almHour;
            `RTCTA_A_ALM_DAY:  n.rdData = st.almDay;
            `RTCTA_A_ALM_WDAY: n.rdData = st.almWday;
            default:           n.rdData = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st         <= '0;
         st.almMin  <= `RTCTA_ALM_RST;
         st.almHour <= `RTCTA_ALM_RST;
         st.almDay  <= `RTCTA_ALM_RST;
         st.almWday <= `RTCTA_ALM_RST;
      end else begin
         st <= n;
      end
   end

   assign rdData  = st.rdData;
   assign tirqOut = st.pinLevel;
   assign tirqOe  = st.tOe;
   assign airqOut = st.pinLevel;
   assign airqOe  = st.aOe;
   assign intOut  = st.pinLevel;
   assign intOe   = st.iOe;

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   logic wrCtrl2;
   assign wrCtrl2 = wrEn && (addr == `RTCTA_A_CTRL2);

   timer_flag_set_a: assert property (tmrEvt |=> st.tf)
      else $error("timer event did not set flag");
   timer_level_clear_a: assert property (wrCtrl2 && !wrData[`RTCTA_B_TF] && !tmrEvt
                                         && !wrData[`RTCTA_B_PULSE] |=> !tirqOe)
      else $error("level mode pin held after flag clear");
   timer_pulse_hold_a: assert property (tmrEvt && st.pulseMode && n.timer_irq_enable && n.pulseMode
                                        |=> tirqOe [*8])
      else $error("pulse mode low period cut short");
   timer_reload_a: assert property (tmrEvt |=> st.count == $past(st.preset))
      else $error("preset not reloaded after event");
   timer_stop_a: assert property (st.state == TMR_IDLE && !(wrEn && addr == `RTCTA_A_PRESET)
                                  && !(n.te && !st.te) |=> $stable(st.count))
      else $error("counter moved while stopped");
   timer_start_a: assert property (st.state == TMR_IDLE && n.te && !st.te
                                   |=> st.state == TMR_RUN && st.count == $past(st.preset))
      else $error("countdown did not start on run bit rise");
   alarm_event_a: assert property (almEvt |=> st.af ##0 (airqOe == st.alarm_irq_enable))
      else $error("alarm event lost");
   alarm_enable_off_a: assert property (wrCtrl2 && !wrData[`RTCTA_B_AIE] |=> !airqOe)
      else $error("alarm pin held after enable clear");
   alarm_flag_clear_a: assert property (wrCtrl2 && !wrData[`RTCTA_B_AF] && !almEvt |=> !airqOe)
      else $error("alarm pin held after flag clear");
   flag_write_one_a: assert property (wrCtrl2 && wrData[`RTCTA_B_TF] && !st.tf && !tmrEvt |=> !st.tf)
      else $error("writing one set the timer flag");
   alarm_all_ignored_a: assert property (ignore == `RTCTA_IGN_ALL |-> !almEvt)
      else $error("alarm with all fields ignored");
   shared_pin_a: assert property (intOe == (tirqOe || airqOe))
      else $error("shared pin not the or of both requests");
   alarm_one_shot_a: assert property (almEvt |=> !almEvt)
      else $error("alarm raised on two cycles in a row");

   // Timer pin requests and drive level of all three pins
   timer_enable_gate_a: assert property (
      tmrEvt && !n.pulseMode && !n.timer_irq_enable
      |=> !tirqOe)
      else $error("timer pin pulled with enable clear");

   timer_level_again_a: assert property (
      tmrEvt && !n.pulseMode && n.timer_irq_enable
      |=> tirqOe && intOe)
      else $error("level event did not pull the pins");

   timer_level_on_a: assert property (
      !n.pulseMode && n.tf && n.timer_irq_enable
      |=> tirqOe)
      else $error("level pin not pulled with flag and enable");

   timer_level_off_a: assert property (
      !n.pulseMode && !n.timer_irq_enable
      |=> !tirqOe)
      else $error("level pin pulled with enable clear");

   timer_flag_gone_a: assert property (
      !n.pulseMode && !n.tf
      |=> !tirqOe)
      else $error("level pin pulled with flag clear");

   pulse_end_release_a: assert property (
      st.pulseMode && n.pulseMode && st.rtn == `RTCTA_RTN_W'(1) && !tmrEvt
      |=> !tirqOe)
      else $error("pulse not released after return period");

   pulse_count_down_a: assert property (
      st.rtn != '0 && !(tmrEvt && st.pulseMode && n.timer_irq_enable)
      |=> st.rtn == $past(st.rtn) - `RTCTA_RTN_W'(1))
      else $error("return period counter skipped");

   pulse_flag_set_a: assert property (
      tmrEvt && st.pulseMode && n.pulseMode && n.timer_irq_enable && st.tf
      |=> tirqOe)
      else $error("pulse missing with flag still set");

   pulse_clear_keep_a: assert property (
      st.pulseMode && n.pulseMode && st.rtn > `RTCTA_RTN_W'(1) && wrCtrl2 && !wrData[`RTCTA_B_TF]
      |=> tirqOe)
      else $error("flag clear cut the pulse");

   pin_level_low_a: assert property (
      !tirqOut && !airqOut
      && !intOut)
      else $error("open drain pin driven high");

   // Counter
   count_zero_idle_a: assert property (
      st.count == `RTCTA_CNT_ZERO
      |-> !tmrEvt)
      else $error("event from a zero count");

   count_step_a: assert property (
      st.state == TMR_RUN && n.te && srcTick && st.count != `RTCTA_CNT_ONE && st.count != `RTCTA_CNT_ZERO
      |=> st.count == $past(st.count) - 8'h01)
      else $error("counter did not step on source tick");

   count_no_tick_a: assert property (
      st.state == TMR_RUN && n.te && !srcTick
      |=> $stable(st.count))
      else $error("counter moved without source tick");

   count_min_source_a: assert property (
      st.state == TMR_RUN && n.te && st.td == `RTCTA_SRC_MIN && !minTick
      |=> $stable(st.count))
      else $error("minute source counted another tick");

   timer_stays_idle_a: assert property (
      st.state == TMR_IDLE && !(n.te && !st.te)
      |=> st.state == TMR_IDLE)
      else $error("countdown started without run bit rise");

   timer_keeps_running_a: assert property (
      tmrEvt
      |=> st.state == TMR_RUN)
      else $error("timer stopped after event");

   timer_run_off_a: assert property (
      st.state == TMR_RUN && !n.te
      |=> st.state == TMR_IDLE)
      else $error("countdown kept going after run clear");

   stop_keeps_flag_a: assert property (
      wrEn && addr == `RTCTA_A_TMR_CTRL && st.tf
      |=> st.tf)
      else $error("run bit write cleared the flag");

   preset_locked_a: assert property (
      wrEn && addr == `RTCTA_A_PRESET && st.te
      |=> $stable(st.preset))
      else $error("preset changed while running");

   // Alarm
   alarm_pin_hold_a: assert property (
      st.af && st.alarm_irq_enable && !wrCtrl2
      |=> airqOe)
      else $error("alarm pin released on its own");

   alarm_masked_a: assert property (
      almEvt && !n.alarm_irq_enable
      |=> st.af && !airqOe)
      else $error("masked alarm pulled the pin");

   alarm_write_one_a: assert property (
      wrCtrl2 && wrData[`RTCTA_B_AF] && !st.af && !almEvt
      |=> !st.af)
      else $error("writing one set the alarm flag");

   alarm_no_match_a: assert property (
      ignore == `RTCTA_IGN_ALL
      |-> !matchNow)
      else $error("match with all fields ignored");

   alarm_held_match_a: assert property (
      matchNow && st.matchPrev
      |-> !almEvt)
      else $error("alarm raised while match persisted");

   level_event_c: cover property (tmrEvt && !st.pulseMode && st.timer_irq_enable);
   pulse_repeat_c: cover property (tmrEvt && st.pulseMode && st.tf);
   alarm_pin_c: cover property (almEvt && st.alarm_irq_enable);
   pulse_end_c: cover property (st.pulseMode && st.rtn == `RTCTA_RTN_W'(1));
   alarm_masked_c: cover property (almEvt && !st.alarm_irq_enable);

endmodule

//--- verilog/rtcta_params.svh
// Register map, field positions, reset values and timing constants of the timer/alarm interrupt block
// Functional notes
// - Two-bit source select picks 4096 Hz, 64 Hz, seconds tick or minutes tick.
// - Interval is source period times 8-bit count; count zero never fires.
// - First interval may be short by up to one source period.
// - Countdown starts when the run bit goes from 0 to 1.
// - Counter drops once per source tick; event when it goes 01h to 00h.
// - Each timer event sets the timer event flag.
// - Timer flag holds until software clears it; stopping does not clear it.
// - Timer event pulls the interrupt low only when timer interrupt enable is set.
// - Level mode: enable bit switches the output while the flag is set.
// - Level mode: clearing the flag releases the output whatever the enable.
// - While running, preset reloads after each event and counting goes on.
// - Level mode: after a clear, next 01h to 00h sets flag and output again.
// - Pulse mode: output low for the return period, then released.
// - Pulse mode: each later event pulls output low even with flag still set.
// - Pulse mode: clearing the flag does not shorten the low period.
// - Countdown stops when the run bit goes from 1 to 0.
// - Alarm event and flag when minute, hour, weekday and date match.
// - Alarm with enable set holds output low until flag or enable cleared.
// - Clearing the alarm enable releases the output at once.
// - Clearing the alarm flag releases the output at once.
// - Alarm with enable clear sets the flag but leaves the output released.
// - Fields with ignore bit set skip compare; all ignored means no alarm.
// - Writing 1 to an event flag does nothing; only 0 clears it.
`ifndef RTCTA_PARAMS_SVH
`define RTCTA_PARAMS_SVH

`define RTCTA_ADDR_W      4
`define RTCTA_A_CTRL2     4'h1
`define RTCTA_A_ALM_MIN   4'h9
`define RTCTA_A_ALM_HOUR  4'ha
`define RTCTA_A_ALM_DAY   4'hb
`define RTCTA_A_ALM_WDAY  4'hc
`define RTCTA_A_TMR_CTRL  4'he
`define RTCTA_A_PRESET    4'hf

`define RTCTA_B_TIE       0
`define RTCTA_B_AIE       1
`define RTCTA_B_TF        2
`define RTCTA_B_AF        3
`define RTCTA_B_PULSE     4
`define RTCTA_B_TE        4
`define RTCTA_B_IGNORE    7

`define RTCTA_SRC_4096    2'h0
`define RTCTA_SRC_64      2'h1
`define RTCTA_SRC_SEC     2'h2
`define RTCTA_SRC_MIN     2'h3

`define RTCTA_CNT_ONE     8'h01
`define RTCTA_CNT_ZERO    8'h00
`define RTCTA_ALM_RST     8'h80
`define RTCTA_IGN_ALL     4'hf

`define RTCTA_CLK_NS      8
`define RTCTA_RTN_NS      15625
`define RTCTA_RTN_CYCLES  ((`RTCTA_RTN_NS + `RTCTA_CLK_NS - 1) / `RTCTA_CLK_NS)
`define RTCTA_RTN_W       16

`endif

//--- verilog/rtcta_pkg.sv
// Types of the timer/alarm interrupt block
`include "rtcta_params.svh"
package rtcta_pkg;

   typedef enum logic [0:0] {
      TMR_IDLE = 1'b0,
      TMR_RUN  = 1'b1
   } rtcta_tmr_t;

   typedef struct packed {
      rtcta_tmr_t              state;
      logic                    te;
      logic [1:0]              td;
      logic                    pulseMode;
      logic                    timer_irq_enable;
      logic                    alarm_irq_enable;
      logic                    tf;
      logic                    af;
      logic [7:0]              preset;
      logic [7:0]              count;
      logic [7:0]              almMin;
      logic [7:0]              almHour;
      logic [7:0]              almDay;
      logic [7:0]              almWday;
      logic                    matchPrev;
      logic [`RTCTA_RTN_W-1:0] rtn;
      logic                    tOe;
      logic                    aOe;
      logic                    iOe;
      logic                    pinLevel;
      logic [7:0]              rdData;
   } rtcta_state_t;

endpackage

//--- verif/rtcta_timebase.sv
// Time base ticks and pulled-up interrupt pins seen by the host side
`timescale 1ns/1ps
module rtcta_timebase (
   input  wire logic [3:0] fire,     // One-hot tick request
   output logic            tick4096, // 4096 Hz source tick
   output logic            tick64,   // 64 Hz source tick
   output logic            secTick,  // Seconds update tick
   output logic            minTick,  // Minutes update tick
   input  wire logic       tirqOut,  // Timer pin drive level
   input  wire logic       tirqOe,   // Timer pin drive enable
   input  wire logic       airqOut,  // Alarm pin drive level
   input  wire logic       airqOe,   // Alarm pin drive enable
   input  wire logic       intOut,   // Shared pin drive level
   input  wire logic       intOe,    // Shared pin drive enable
   output logic            tirqPin,  // Resolved timer pin
   output logic            airqPin,  // Resolved alarm pin
   output logic            intPin    // Resolved shared pin
);
   assign {minTick, secTick, tick64, tick4096} = fire;
   // External pull-ups win when nobody drives
   assign tirqPin = tirqOe ? tirqOut : 1'b1;
   assign airqPin = airqOe ? airqOut : 1'b1;
   assign intPin  = intOe ? intOut : 1'b1;
endmodule

//--- verif/testbench.sv
// Register-level tests of the timer/alarm interrupt block
`timescale 1ns/1ps
`include "rtcta_params.svh"
module testbench;
   localparam int RTN   = 10;
   localparam int LIMIT = 20000;
   logic       clock = 1'b0;
   logic       reset_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wrData = 8'h00;
   logic       wrEn = 1'b0;
   logic       rdEn = 1'b0;
   logic [7:0] rdData;
   logic [3:0] fire = 4'h0;
   logic       tick4096, tick64, secTick, minTick;
   logic [6:0] curMinute = 7'h29;
   logic [5:0] curHour = 6'h08;
   logic [5:0] curDay = 6'h15;
   logic [2:0] curWeekday = 3'h1;
   logic       tirqOut, tirqOe, airqOut, airqOe, intOut, intOe;
   logic       tirqPin, airqPin, intPin;
   int         n_errors = 0;
   int         checks = 0;
   int         cycles = 0;
   int         run = 0;
   int         lastRun = 0;

   always #4 clock = ~clock;

   rtcta_irq #(.RTN_CYCLES(`RTCTA_RTN_W'(RTN))) i_rtcta_irq (.clock(clock), .reset_n(reset_n), .addr(addr),
      .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .tick4096(tick4096), .tick64(tick64),
      .secTick(secTick), .minTick(minTick), .curMinute(curMinute), .curHour(curHour), .curDay(curDay),
      .curWeekday(curWeekday), .tirqOut(tirqOut), .tirqOe(tirqOe), .airqOut(airqOut), .airqOe(airqOe),
      .intOut(intOut), .intOe(intOe));

   rtcta_timebase i_rtcta_timebase (.fire(fire), .tick4096(tick4096), .tick64(tick64), .secTick(secTick),
      .minTick(minTick), .tirqOut(tirqOut), .tirqOe(tirqOe), .airqOut(airqOut), .airqOe(airqOe),
      .intOut(intOut), .intOe(intOe), .tirqPin(tirqPin), .airqPin(airqPin), .intPin(intPin));

   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_errors++;
         tally_and_finish();
      end
   end

   // Length of each low run on the timer pin
   always @(negedge clock) begin
      if (tirqOe === 1'b1) begin
         run++;
      end else if (run != 0) begin
         lastRun = run;
         run = 0;
      end
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clock);
      wrEn <= 1'b0;
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clock);
      rdEn <= 1'b0;
      @(negedge clock);
      chk($sformatf("reg %h", a), rdData, exp);
   endtask

   task automatic tick(input int s);
      @(posedge clock);
      fire <= 4'h1 << s;
      @(posedge clock);
      fire <= 4'h0;
   endtask

   task automatic setMin(input logic [6:0] v);
      @(posedge clock);
      curMinute <= v;
   endtask

   task automatic pins(input logic t, input logic a);
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk("tirqPin", tirqPin, !t);
      chk("airqPin", airqPin, !a);
      chk("intPin", intPin, !(t | a));
   endtask

   initial begin
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      rdchk(`RTCTA_A_CTRL2, 8'h00);
      rdchk(`RTCTA_A_ALM_MIN, 8'h80);
      rdchk(`RTCTA_A_PRESET, 8'h00);
      wr(4'h0, 8'hff);
      rdchk(4'h0, 8'h00);
      $display("Test reset done");
      for (int s = 0; s < 4; s++) begin
         wr(`RTCTA_A_TMR_CTRL, 8'h00);
         wr(`RTCTA_A_CTRL2, 8'h01);
         wr(`RTCTA_A_PRESET, 8'h02);
         wr(`RTCTA_A_TMR_CTRL, 8'h10 | 8'(s));
         tick((s + 1) % 4);
         tick(s);
         pins(0, 0);
         rdchk(`RTCTA_A_PRESET, 8'h01);
         rdchk(`RTCTA_A_PRESET, 8'h01);
         tick(s);
         pins(1, 0);
      end
      rdchk(`RTCTA_A_CTRL2, 8'h05);
      wr(`RTCTA_A_CTRL2, 8'h04);
      pins(0, 0);
      rdchk(`RTCTA_A_CTRL2, 8'h04);
      wr(`RTCTA_A_CTRL2, 8'h05);
      pins(1, 0);
      wr(`RTCTA_A_CTRL2, 8'h01);
      pins(0, 0);
      tick(3);
      tick(3);
      pins(1, 0);
      wr(`RTCTA_A_TMR_CTRL, 8'h00);
      pins(1, 0);
      rdchk(`RTCTA_A_CTRL2, 8'h05);
      wr(`RTCTA_A_CTRL2, 8'h01);
      tick(3);
      tick(3);
      pins(0, 0);
      wr(`RTCTA_A_PRESET, 8'h00);
      wr(`RTCTA_A_TMR_CTRL, 8'h13);
      repeat (3) tick(3);
      pins(0, 0);
      $display("Test level done");
      wr(`RTCTA_A_TMR_CTRL, 8'h00);
      wr(`RTCTA_A_CTRL2, 8'h11);
      wr(`RTCTA_A_PRESET, 8'h01);
      wr(`RTCTA_A_TMR_CTRL, 8'h10);
      lastRun = 0;
      tick(0);
      wr(`RTCTA_A_CTRL2, 8'h11);
      repeat (RTN + 4) @(posedge clock);
      chk("pulseLen", lastRun, RTN);
      tick(0);
      repeat (RTN + 4) @(posedge clock);
      lastRun = 0;
      tick(0);
      repeat (RTN + 4) @(posedge clock);
      chk("pulseLen", lastRun, RTN);
      rdchk(`RTCTA_A_CTRL2, 8'h15);
      pins(0, 0);
      wr(`RTCTA_A_TMR_CTRL, 8'h00);
      wr(`RTCTA_A_CTRL2, 8'h02);
      $display("Test pulse done");
      wr(`RTCTA_A_ALM_HOUR, 8'h07);
      wr(`RTCTA_A_ALM_MIN, 8'h30);
      setMin(7'h30);
      pins(0, 0);
      setMin(7'h29);
      wr(`RTCTA_A_ALM_HOUR, 8'h08);
      setMin(7'h30);
      pins(0, 1);
      wr(`RTCTA_A_CTRL2, 8'h0a);
      rdchk(`RTCTA_A_CTRL2, 8'h0a);
      wr(`RTCTA_A_CTRL2, 8'h08);
      pins(0, 0);
      wr(`RTCTA_A_CTRL2, 8'h0a);
      pins(0, 1);
      wr(`RTCTA_A_CTRL2, 8'h02);
      pins(0, 0);
      repeat (5) @(posedge clock);
      rdchk(`RTCTA_A_CTRL2, 8'h02);
      wr(`RTCTA_A_CTRL2, 8'h00);
      setMin(7'h31);
      setMin(7'h30);
      pins(0, 0);
      rdchk(`RTCTA_A_CTRL2, 8'h08);
      wr(`RTCTA_A_CTRL2, 8'h00);
      wr(`RTCTA_A_ALM_DAY, 8'h15);
      wr(`RTCTA_A_ALM_WDAY, 8'h02);
      setMin(7'h29);
      setMin(7'h30);
      rdchk(`RTCTA_A_CTRL2, 8'h00);
      wr(`RTCTA_A_ALM_WDAY, 8'h01);
      rdchk(`RTCTA_A_CTRL2, 8'h08);
      wr(`RTCTA_A_CTRL2, 8'h00);
      wr(`RTCTA_A_ALM_DAY, 8'h80);
      wr(`RTCTA_A_ALM_WDAY, 8'h80);
      wr(`RTCTA_A_ALM_HOUR, 8'h80);
      wr(`RTCTA_A_ALM_MIN, 8'h80);
      setMin(7'h29);
      setMin(7'h30);
      rdchk(`RTCTA_A_CTRL2, 8'h00);
      $display("Test alarm done");
      tally_and_finish();
   end
endmodule
